// ---- sdt_pkg.sv ----
// Shared constants of the down timer: register map, field layout,
// reset values, mode codes and timing counts.
// Assumes a byte-wide paged register file on the core clock.
package sdt_pkg;

  // Register page and word offsets of instance zero
  localparam logic [7:0] SDT_PAGE = 8'h0b;
  localparam logic [7:0] SDT_OFS_COUNT_HIGH = 8'hf0;
  localparam logic [7:0] SDT_OFS_COUNT_LOW = 8'hf1;
  localparam logic [7:0] SDT_OFS_PRESCALE = 8'hf2;
  localparam logic [7:0] SDT_OFS_CONTROL = 8'hf3;
  localparam logic [7:0] SDT_INST_STRIDE = 8'h04;

  // Reset values
  localparam logic [7:0] SDT_RST_COUNT_HIGH = 8'hff;
  localparam logic [7:0] SDT_RST_COUNT_LOW = 8'hff;
  localparam logic [7:0] SDT_RST_PRESCALE = 8'hff;
  localparam logic [7:0] SDT_RST_CONTROL = 8'h14;

  // Control field positions
  localparam int SDT_BIT_RUN = 7;
  localparam int SDT_BIT_SINGLE = 6;
  localparam int SDT_BIT_IMODE_HI = 5;
  localparam int SDT_BIT_IMODE_LO = 4;
  localparam int SDT_BIT_IN_EN = 3;
  localparam int SDT_BIT_IRQ_SEL = 2;
  localparam int SDT_BIT_OMODE_HI = 1;
  localparam int SDT_BIT_OMODE_LO = 0;

  // Input mode codes
  localparam logic [1:0] SDT_IN_EVENT = 2'h0;
  localparam logic [1:0] SDT_IN_GATED = 2'h1;
  localparam logic [1:0] SDT_IN_TRIG = 2'h2;
  localparam logic [1:0] SDT_IN_RETRIG = 2'h3;

  // Output mode codes for a released pin and a square wave
  localparam logic [1:0] SDT_OUT_NONE = 2'h0;
  localparam logic [1:0] SDT_OUT_SQUARE = 2'h1;

  // Internal tick is the core clock divided by four
  localparam int SDT_INT_DIV = 4;
  localparam logic [1:0] SDT_INT_DIV_LAST = 2'(SDT_INT_DIV - 1);

  // Run state, one-hot
  typedef enum logic [2:0] {
    SDT_ST_IDLE = 3'h1,
    SDT_ST_ARMED = 3'h2,
    SDT_ST_COUNT = 3'h4
  } sdt_state_t;

endpackage

// ---- sdt_psc_if.sv ----
// Link between the down timer core and its prescaler.
// Assumes both ends sit on clk_sys.
`timescale 1ns/1ps
interface sdt_psc_if;
  logic in_tick;
  logic restart;
  logic [7:0] divisor;
  logic out_tick;

  modport core (output in_tick, output restart, output divisor, input out_tick);
  modport psc (input in_tick, input restart, input divisor, output out_tick);
endinterface

// ---- sdt_prescaler.sv ----
// 8-bit prescaler of the down timer: one output tick per divisor+1
// input ticks.
// Assumes in_tick is a one-cycle strobe on clk_sys.
`timescale 1ns/1ps
module sdt_prescaler
  import sdt_pkg::*;
(
  input wire logic clk_sys, // Core clock
  input wire logic resetn, // Synchronous reset, low active
  input wire logic ce, // Clock enable, freezes state when low
  sdt_psc_if.psc link // Tick in, divided tick out
);

  logic [7:0] left_reg;
  logic [7:0] left_next;
  logic at_end;

  // Divisor is read live, so a new value acts at the next reload or restart
  assign at_end = (left_reg == 8'h00);
  assign link.out_tick = link.in_tick & at_end;

  always_comb begin
    left_next = left_reg;
    if (link.restart) begin
      left_next = link.divisor;
    end else if (link.in_tick) begin
      left_next = at_end ? link.divisor : left_reg - 8'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      left_reg <= SDT_RST_PRESCALE;
    end else if (ce) begin
      left_reg <= left_next;
    end
  end

endmodule

// ---- sdt_down_timer.sv ----
// Down timer: 16-bit down counter behind an 8-bit prescaler, with
// output pin modes and an interrupt request shared with an external pin.
// Assumes a byte-wide paged register file with one-cycle strobes on
// clk_sys; pin inputs are asynchronous and are synchronised here.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Without input pin, event mode counts the oscillator clock.
// - Output mode 00 releases the output pin, held high.
// - Output mode 01 toggles the output pin at each end of count.
// - Output mode 1x copies the low mode bit to the pin at end of count.
// - Select bit 0 sends end of count as request; 1 passes external pin.
// - The request shares the external interrupt channel.
// - Four byte registers: high, low, prescaler, control; page 11 from F0h.
// - Reset: count and prescaler read FFh, control reads 14h.
// - Count writes set the constant; reads give the live count.
// - Prescaler read returns the programmed value.
// - Prescaler divides by value plus one.
// - Control bit 7 starts and stops counting.
// - Control bit 6: continuous when 0, single shot when 1.
// - Bits 5:4 pick event, gated, triggerable, retriggerable input.
// - Bit 3 enables input section; software keeps it 0 without input.
// - End of count is the underflow past zero.
// - Single mode stops, reloads, clears start; continuous reloads.
// - New constant acts at next end of count; prescaler at once.
// - Input disabled counts core clock over four, pin ignored.
module sdt_down_timer
  import sdt_pkg::*;
#(
  parameter int INSTANCE = 0, // Timer number 0..3 in the register group
  parameter bit HAS_INPUT_PIN = 1'b1 // 0: input wired to oscillator clock
)(
  input wire logic clk_sys, // Core clock, 100 MHz
  input wire logic resetn, // Synchronous reset, low active
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic [7:0] reg_page, // Register page of the access
  input wire logic [7:0] reg_addr, // Register address in the page
  input wire logic reg_wr, // Write strobe, one cycle
  input wire logic reg_rd, // Read strobe, one cycle
  input wire logic [7:0] reg_wdata, // Write data
  output logic [7:0] reg_rdata, // Read data, valid the cycle after reg_rd
  input wire logic timer_input_pin, // Asynchronous timer input pin
  input wire logic oscillator_derived_clock, // Asynchronous oscillator clock
  input wire logic ext_irq_pin, // Asynchronous external interrupt pin
  output logic timer_output_pin, // Timer output pin
  output logic irq_channel // Shared external interrupt channel level
);

  ////////////////////////////////////////////////////////////////////////
  // Address decode

  localparam logic [7:0] INST_OFS = 8'(INSTANCE * 4);

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs + INST_OFS);
  endfunction

  wire page_ok = (reg_page == SDT_PAGE);
  wire sel_high = page_ok & hit(reg_addr, SDT_OFS_COUNT_HIGH);
  wire sel_low = page_ok & hit(reg_addr, SDT_OFS_COUNT_LOW);
  wire sel_psc = page_ok & hit(reg_addr, SDT_OFS_PRESCALE);
  wire sel_ctl = page_ok & hit(reg_addr, SDT_OFS_CONTROL);
  wire wr_high = reg_wr & sel_high;
  wire wr_low = reg_wr & sel_low;
  wire wr_psc = reg_wr & sel_psc;
  wire wr_ctl = reg_wr & sel_ctl;

  ////////////////////////////////////////////////////////////////////////
  // Registers

  logic [15:0] const_reg;
  logic [7:0] psc_reg;
  logic [7:0] ctl_reg;
  logic [7:0] ctl_next;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic new_const_reg;
  logic out_reg;
  logic irq_reg;
  sdt_state_t state_reg;
  sdt_state_t state_next;

  wire run_bit = ctl_reg[SDT_BIT_RUN];
  wire single_bit = ctl_reg[SDT_BIT_SINGLE];
  wire [1:0] in_mode = {ctl_reg[SDT_BIT_IMODE_HI], ctl_reg[SDT_BIT_IMODE_LO]};
  wire in_en = ctl_reg[SDT_BIT_IN_EN];
  wire irq_sel = ctl_reg[SDT_BIT_IRQ_SEL];
  wire [1:0] out_mode = {ctl_reg[SDT_BIT_OMODE_HI], ctl_reg[SDT_BIT_OMODE_LO]};

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, a change counts once stages two
  // and three agree. Stage one feeds only stage two.

  logic [2:0] tin_sync_reg;
  logic [2:0] osc_sync_reg;
  logic [2:0] ext_sync_reg;
  logic tin_lvl_reg;
  logic ext_lvl_reg;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      tin_sync_reg <= 3'h7;
      osc_sync_reg <= 3'h7;
      ext_sync_reg <= 3'h0;
    end else if (ce) begin
      tin_sync_reg <= {tin_sync_reg[1:0], timer_input_pin};
      osc_sync_reg <= {osc_sync_reg[1:0], oscillator_derived_clock};
      ext_sync_reg <= {ext_sync_reg[1:0], ext_irq_pin};
    end
  end

  // Where no input pin exists, the oscillator clock takes its place
  wire src_s2 = HAS_INPUT_PIN ? tin_sync_reg[1] : osc_sync_reg[1];
  wire src_s3 = HAS_INPUT_PIN ? tin_sync_reg[2] : osc_sync_reg[2];
  wire src_agree = (src_s2 == src_s3);
  wire src_fall = src_agree & tin_lvl_reg & ~src_s3;
  wire src_high = tin_lvl_reg;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      tin_lvl_reg <= 1'b1;
      ext_lvl_reg <= 1'b0;
    end else if (ce) begin
      if (src_agree) begin
        tin_lvl_reg <= src_s3;
      end
      if (ext_sync_reg[1] == ext_sync_reg[2]) begin
        ext_lvl_reg <= ext_sync_reg[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Internal time base: core clock over four

  logic [1:0] div4_reg;
  wire div4_tick = (div4_reg == SDT_INT_DIV_LAST);

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      div4_reg <= 2'h0;
    end else if (ce) begin
      div4_reg <= div4_reg + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Count source selection

  wire mode_event = in_en & (in_mode == SDT_IN_EVENT);
  wire mode_gated = in_en & (in_mode == SDT_IN_GATED);
  wire mode_trig = in_en & (in_mode == SDT_IN_TRIG);
  wire mode_retrig = in_en & (in_mode == SDT_IN_RETRIG);

  // With the input section off, the pin is never looked at
  wire src_tick = mode_event ? src_fall : div4_tick;
  wire gate_ok = ~mode_gated | src_high;
  wire counting = (state_reg == SDT_ST_COUNT) & gate_ok;
  wire retrig = mode_retrig & src_fall & (state_reg == SDT_ST_COUNT);

  // Restarting after a stop with a fresh constant reloads everything
  wire start_load = (state_reg == SDT_ST_IDLE) & run_bit & new_const_reg;

  sdt_psc_if psc_link ();

  assign psc_link.in_tick = counting & src_tick;
  assign psc_link.restart = retrig | start_load | wr_psc;
  assign psc_link.divisor = wr_psc ? reg_wdata : psc_reg;

  sdt_prescaler u_psc (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .ce(ce),
    .link(psc_link)
  );

  wire cnt_step = psc_link.out_tick;
  wire eoc = cnt_step & (cnt_reg == 16'h0000);

  ////////////////////////////////////////////////////////////////////////
  // Run state

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SDT_ST_IDLE: begin
        if (run_bit) begin
          state_next = mode_trig ? SDT_ST_ARMED : SDT_ST_COUNT;
        end
      end
      SDT_ST_ARMED: begin
        if (!run_bit) begin
          state_next = SDT_ST_IDLE;
        end else if (src_fall) begin
          state_next = SDT_ST_COUNT;
        end
      end
      SDT_ST_COUNT: begin
        if (!run_bit || (eoc && single_bit)) begin
          state_next = SDT_ST_IDLE;
        end
      end
      default: state_next = SDT_ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Counter

  always_comb begin
    cnt_next = cnt_reg;
    if (retrig || start_load) begin
      cnt_next = const_reg;
    end else if (eoc) begin
      cnt_next = const_reg;
    end else if (cnt_step) begin
      cnt_next = cnt_reg - 16'h0001;
    end
  end

  // Hardware clears the start bit on a single-shot end of count;
  // a software write in the same cycle wins so a restart is not lost.
  always_comb begin
    ctl_next = ctl_reg;
    if (eoc && single_bit) begin
      ctl_next[SDT_BIT_RUN] = 1'b0;
    end
    if (wr_ctl) begin
      ctl_next = reg_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      const_reg <= {SDT_RST_COUNT_HIGH, SDT_RST_COUNT_LOW};
      psc_reg <= SDT_RST_PRESCALE;
      ctl_reg <= SDT_RST_CONTROL;
      cnt_reg <= {SDT_RST_COUNT_HIGH, SDT_RST_COUNT_LOW};
      new_const_reg <= 1'b0;
      state_reg <= SDT_ST_IDLE;
    end else if (ce) begin
      if (wr_high) begin
        const_reg[15:8] <= reg_wdata;
      end
      if (wr_low) begin
        const_reg[7:0] <= reg_wdata;
      end
      if (wr_psc) begin
        psc_reg <= reg_wdata;
      end
      ctl_reg <= ctl_next;
      cnt_reg <= cnt_next;
      state_reg <= state_next;
      // Remember a constant written while stopped
      if ((wr_high || wr_low) && !run_bit) begin
        new_const_reg <= 1'b1;
      end else if (start_load || eoc || retrig) begin
        new_const_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output pin and interrupt channel

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      out_reg <= 1'b1;
      irq_reg <= 1'b0;
    end else if (ce) begin
      if (out_mode == SDT_OUT_NONE) begin
        out_reg <= 1'b1;
      end else if (eoc && out_mode == SDT_OUT_SQUARE) begin
        out_reg <= ~out_reg;
      end else if (eoc && out_mode[1]) begin
        out_reg <= out_mode[0];
      end
      // Channel carries the timer pulse or the external pin level.
      // Changing the select can make a false edge; software guards it.
      irq_reg <= irq_sel ? ext_lvl_reg : eoc;
    end
  end

  assign timer_output_pin = out_reg;
  assign irq_channel = irq_reg;

  ////////////////////////////////////////////////////////////////////////
  // Read data

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (ce && reg_rd) begin
      if (sel_high) begin
        reg_rdata <= cnt_reg[15:8];
      end else if (sel_low) begin
        reg_rdata <= cnt_reg[7:0];
      end else if (sel_psc) begin
        reg_rdata <= psc_reg;
      end else if (sel_ctl) begin
        reg_rdata <= ctl_reg;
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

endmodule

// ---- sdt_down_timer_sva.sv ----
// Port-level assertions for the down timer.
// Assumes one clk_sys domain; shadows software writes to mode bits.
`timescale 1ns/1ps
module sdt_down_timer_sva
  import sdt_pkg::*;
#(
  parameter int INSTANCE = 0
)(
  input wire logic clk_sys, // Clock
  input wire logic resetn, // Reset, low active
  input wire logic ce, // Enable
  input wire logic [7:0] reg_page, // Page
  input wire logic [7:0] reg_addr, // Address
  input wire logic reg_wr, // Write
  input wire logic reg_rd, // Read
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic [7:0] reg_rdata, // Read data
  input wire logic timer_input_pin, // Input pin
  input wire logic oscillator_derived_clock, // Oscillator clock
  input wire logic ext_irq_pin, // External pin
  input wire logic timer_output_pin, // Output pin
  input wire logic irq_channel // Channel level
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  localparam logic [7:0] BASE = SDT_OFS_COUNT_HIGH + 8'(4 * INSTANCE);
  logic [7:0] ctl_reg;
  logic [7:0] psc_reg;
  logic [1:0] age_reg;
  logic [3:0] ext_age_reg;
  logic ext_last_reg;
  wire logic hit = ce && reg_page == SDT_PAGE;
  wire logic ctl_wr = hit && reg_wr && reg_addr == BASE + 8'h03;
  wire logic psc_wr = hit && reg_wr && reg_addr == BASE + 8'h02;
  wire logic settled = age_reg == 2'h3;

  ////////////////////////////////////////////////////////////////////
  // Mode shadow; age lets the registered outputs catch up after a write
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ctl_reg <= SDT_RST_CONTROL;
      psc_reg <= SDT_RST_PRESCALE;
      age_reg <= 2'h0;
      ext_age_reg <= 4'h0;
      ext_last_reg <= 1'b0;
    end else begin
      ctl_reg <= ctl_wr ? reg_wdata : ctl_reg;
      psc_reg <= psc_wr ? reg_wdata : psc_reg;
      age_reg <= ctl_wr ? 2'h0 : (settled ? age_reg : age_reg + 2'h1);
      ext_last_reg <= ext_irq_pin;
      ext_age_reg <= (ext_irq_pin != ext_last_reg) ? 4'h0 :
                     (ext_age_reg == 4'h8 ? ext_age_reg : ext_age_reg + 4'h1);
    end
  end

  ////////////////////////////////////////////////////////////////////
  a_out_released_high: assert property (
    settled && ctl_reg[1:0] == SDT_OUT_NONE |-> timer_output_pin)
    else $error("output pin not high in released mode");
  a_square_toggle_tie: assert property (
    settled && ctl_reg[1:0] == SDT_OUT_SQUARE && !ctl_reg[2]
    |-> $changed(timer_output_pin) == irq_channel)
    else $error("square output and end of count disagree");
  a_pwm_copy_bit: assert property (
    settled && ctl_reg[1] && !ctl_reg[2] && irq_channel |-> timer_output_pin == ctl_reg[0])
    else $error("pwm output does not follow low mode bit");
  a_irq_one_pulse: assert property (
    settled && !ctl_reg[2] && irq_channel |=> !irq_channel)
    else $error("timer request longer than one cycle");
  a_ext_level_pass: assert property (
    settled && ctl_reg[2] && ext_age_reg == 4'h8 |-> irq_channel == ext_irq_pin)
    else $error("external level not passed to channel");
  a_unmapped_reads_zero: assert property (
    ce && reg_rd && reg_page != SDT_PAGE |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_prescale_readback: assert property (
    hit && reg_rd && !reg_wr && reg_addr == BASE + 8'h02 |=> reg_rdata == psc_reg)
    else $error("prescaler read differs from programmed value");
  a_control_readback: assert property (
    hit && reg_rd && !reg_wr && reg_addr == BASE + 8'h03 |=> reg_rdata[6:0] == ctl_reg[6:0])
    else $error("control read differs from written value");
  c_square_eoc: cover property (irq_channel && ctl_reg[1:0] == SDT_OUT_SQUARE);
  c_single_eoc: cover property (irq_channel && ctl_reg[6]);
  c_ext_pass: cover property (irq_channel && ctl_reg[2]);
endmodule

bind sdt_down_timer sdt_down_timer_sva #(.INSTANCE(INSTANCE)) i_sdt_down_timer_sva (
  .clk_sys(clk_sys), .resetn(resetn), .ce(ce), .reg_page(reg_page), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .timer_input_pin(timer_input_pin), .oscillator_derived_clock(oscillator_derived_clock),
  .ext_irq_pin(ext_irq_pin), .timer_output_pin(timer_output_pin), .irq_channel(irq_channel));

// ---- sdt_irq_sink.sv ----
// CPU side of the shared interrupt channel: pending flag and request count.
// Assumes irq_channel is registered on clk_sys.
`timescale 1ns/1ps
module sdt_irq_sink (
  input wire logic clk_sys, // Clock
  input wire logic resetn, // Reset, low active
  input wire logic irq_channel, // Channel level
  input wire logic clr, // Clear pending
  output logic pend, // Pending request
  output logic [15:0] hits // Requests seen
);
  logic last_reg;
  // Edge sensitive, so a level held by the external pin counts once
  wire logic rise = irq_channel && !last_reg;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      last_reg <= 1'b0;
      pend <= 1'b0;
      hits <= 16'h0000;
    end else begin
      last_reg <= irq_channel;
      pend <= rise || (pend && !clr);
      hits <= hits + 16'(rise);
    end
  end
endmodule

// ---- tb.sv ----
// Self-checking bench for the down timer through its register port.
// Assumes instance zero; the oscillator input is unused with a pin present.
`timescale 1ns/1ps
module tb;
  import sdt_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic in_pin = 1'b1;
  logic ext_pin = 1'b0;
  logic clr = 1'b0;
  logic ce = 1'b1;
  logic [7:0] reg_page = 8'h00;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [7:0] d;
  logic [15:0] hits;
  logic [15:0] h;
  logic timer_output_pin, irq_channel, pend, p;
  int fails = 0;
  int checks_done = 0;
  int n;

  sdt_down_timer i_sdt_down_timer (.clk_sys(clk_sys), .resetn(resetn), .ce(ce),
    .reg_page(reg_page), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .timer_input_pin(in_pin),
    .oscillator_derived_clock(1'b0), .ext_irq_pin(ext_pin),
    .timer_output_pin(timer_output_pin), .irq_channel(irq_channel));
  sdt_irq_sink i_sdt_irq_sink (.clk_sys(clk_sys), .resetn(resetn),
    .irq_channel(irq_channel), .clr(clr), .pend(pend), .hits(hits));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  // One strobe cycle; read data is settled by the next falling edge
  task automatic acc(input logic w, input logic [7:0] pg, a, v);
    reg_page = pg;
    reg_addr = a;
    reg_wdata = v;
    reg_wr = w;
    reg_rd = !w;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    d = reg_rdata;
    // Idle cycle, so a following call never raises a strobe in the same step
    @(negedge clk_sys);
  endtask

  task automatic wait_irq(output int cyc);
    logic [15:0] h0;
    h0 = hits;
    cyc = 0;
    while (hits == h0) begin
      @(negedge clk_sys);
      cyc++;
      if (cyc > 2000) begin
        fails++;
        $display("unexpected at %0t: no interrupt", $time);
        end_of_test();
      end
    end
  endtask

  task automatic quiet(input int cyc);
    h = hits;
    repeat (cyc) @(negedge clk_sys);
    chk(8'(hits - h), 8'h00);
  endtask

  // Stop, set constant 0005 while stopped, then restart with ctl
  task automatic restart(input logic [7:0] ctl);
    acc(1'b1, SDT_PAGE, SDT_OFS_CONTROL, 8'h01);
    acc(1'b1, SDT_PAGE, SDT_OFS_COUNT_LOW, 8'h05);
    acc(1'b1, SDT_PAGE, SDT_OFS_CONTROL, ctl);
  endtask

  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(negedge clk_sys);
    resetn = 1'b1;
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, SDT_PAGE, SDT_OFS_COUNT_HIGH + 8'(i), 8'h00);
      chk(d, (i == 3) ? 8'h14 : 8'hff);
    end
    chk({7'h0, timer_output_pin}, 8'h01);
    acc(1'b1, 8'h0a, SDT_OFS_CONTROL, 8'h81);
    acc(1'b0, 8'h0a, SDT_OFS_CONTROL, 8'h00);
    chk(d, 8'h00);
    acc(1'b0, SDT_PAGE, 8'hef, 8'h00);
    chk(d, 8'h00);
    acc(1'b0, SDT_PAGE, SDT_OFS_CONTROL, 8'h00);
    chk(d, 8'h14);
    // Constant 0002, divide by 2, internal tick: 3*2*4 = 24 clocks
    acc(1'b1, SDT_PAGE, SDT_OFS_COUNT_HIGH, 8'h00);
    acc(1'b1, SDT_PAGE, SDT_OFS_COUNT_LOW, 8'h02);
    acc(1'b1, SDT_PAGE, SDT_OFS_PRESCALE, 8'h01);
    acc(1'b0, SDT_PAGE, SDT_OFS_PRESCALE, 8'h00);
    chk(d, 8'h01);
    acc(1'b1, SDT_PAGE, SDT_OFS_CONTROL, 8'h81);
    wait_irq(n);
    p = timer_output_pin;
    wait_irq(n);
    chk(8'(n), 8'h18);
    chk({7'h0, timer_output_pin}, {7'h0, !p});
    // Clock enable low freezes counter and prescaler, so no end of count
    ce = 1'b0;
    quiet(100);
    ce = 1'b1;
    acc(1'b1, SDT_PAGE, SDT_OFS_COUNT_LOW, 8'h05);
    wait_irq(n);
    acc(1'b0, SDT_PAGE, SDT_OFS_COUNT_LOW, 8'h00);
    chk(d, 8'h05);
    // The read costs cycles, so the period is taken between two requests
    wait_irq(n);
    wait_irq(n);
    chk(8'(n), 8'h30);
    acc(1'b1, SDT_PAGE, SDT_OFS_CONTROL, 8'h01);
    quiet(100);
    acc(1'b1, SDT_PAGE, SDT_OFS_CONTROL, 8'h82);
    wait_irq(n);
    chk({7'h0, timer_output_pin}, 8'h00);
    acc(1'b1, SDT_PAGE, SDT_OFS_CONTROL, 8'h83);
    wait_irq(n);
    chk({7'h0, timer_output_pin}, 8'h01);
    restart(8'hc1);
    wait_irq(n);
    acc(1'b0, SDT_PAGE, SDT_OFS_CONTROL, 8'h00);
    chk(d, 8'h41);
    quiet(100);
    // Clear pending, one idle cycle, then move the source to the pin
    clr = 1'b1;
    @(negedge clk_sys);
    clr = 1'b0;
    @(negedge clk_sys);
    restart(8'h85);
    ext_pin = 1'b1;
    repeat (8) @(negedge clk_sys);
    chk({7'h0, irq_channel}, 8'h01);
    chk({7'h0, pend}, 8'h01);
    ext_pin = 1'b0;
    repeat (8) @(negedge clk_sys);
    quiet(100);
    in_pin = 1'b0;
    restart(8'h99);
    quiet(120);
    in_pin = 1'b1;
    wait_irq(n);
    wait_irq(n);
    chk(8'(n), 8'h30);
    // Event mode: 6 steps of divide by 2 need 12 falling edges
    restart(8'h89);
    h = hits;
    for (int i = 0; i < 12; i++) begin
      if (i == 11) chk(8'(hits - h), 8'h00);
      in_pin = 1'b0;
      repeat (4) @(negedge clk_sys);
      in_pin = 1'b1;
      repeat (4) @(negedge clk_sys);
    end
    repeat (8) @(negedge clk_sys);
    chk(8'(hits - h), 8'h01);
    restart(8'ha9);
    quiet(100);
    in_pin = 1'b0;
    wait_irq(n);
    wait_irq(n);
    chk(8'(n), 8'h30);
    // Retriggerable: a fall every 20 clocks reloads before any end of count
    in_pin = 1'b1;
    restart(8'hb9);
    h = hits;
    for (int i = 0; i < 6; i++) begin
      in_pin = 1'b0;
      repeat (4) @(negedge clk_sys);
      in_pin = 1'b1;
      repeat (16) @(negedge clk_sys);
    end
    chk(8'(hits - h), 8'h00);
    wait_irq(n);
    end_of_test();
  end
endmodule
